/* File: hdl/link_maint_consts.vh */
// constants for the link maintenance handler
//
// Notes on behaviour
// - software command write emits aligned link-request
// - only one outbound link-request pending at once
// - answer input-status with aligned link-response
// - per-port request and response registers, polled
// - hardware issues requests for recovery and init
// - three commands; only input-status gets response
// - accepted reset restarts registers and all state but the input synchroniser
// - reset only after four consecutive reset requests
// - response carries expected tag and port status
// - flush earlier ack symbols before the response
// - input-status restarts port after error stop
// - input-status also restarts retry-stopped port
// - training: 256 patterns, one idle, then resume
// - status: ok, error, retry- or error-stopped
// - retry stop cleared by restart or input-status
// - error stop cleared only by input-status
// - sender uses returned tag to pick retransmit
// - same protocol for byte or two-byte ports
// - control symbols go out with inverted copy
// - second input-status request before response: protocol error
`ifndef LINK_MAINT_CONSTS_VH
`define LINK_MAINT_CONSTS_VH
// symbol type field in bits 15:12
`define SYM_TYPE_HI      15
`define SYM_TYPE_LO      12
`define TYPE_IDLE        4'h0
`define TYPE_RESTART     4'h3
`define TYPE_LREQ        4'h4
`define TYPE_LRESP       4'h6
// request command in bits 2:0
`define CMD_HI           2
`define CMD_LO           0
`define CMD_TRAIN        3'h0
`define CMD_RESET        3'h3
`define CMD_STATUS       3'h4
// response: tag in bits 10:6, status in bits 3:0
`define TAG_LO           6
`define STAT_OK          4'h0
`define STAT_ERROR       4'h1
`define STAT_ERR_STOP    4'h5
`define STAT_RETRY_STOP  4'h6
// timing and counts
`define RESET_COUNT      3'h4
`define TRAIN_COUNT      9'h100
`define TRAIN_PATTERN    16'hff00
`endif

/* File: hdl/link_maint.v */
// link maintenance handler of one link port
`timescale 1ns/1ns
`include "link_maint_consts.vh"
module link_maint #(
  parameter TAG_W = 5
) (
  // clock and reset
  input  wire             i_ref_clk,
  input  wire             i_srst,
  // receive side, link domain
  input  wire             i_lnk_clk,
  input  wire [15:0]      i_rx_word,
  input  wire             i_rx_ctl,
  // transmit symbol stream
  output wire             o_tx_valid,
  input  wire             i_tx_ready,
  output reg  [15:0]      o_tx_word,
  output reg              o_tx_ctl,
  output wire             o_training,
  // software request and response registers
  input  wire             i_sw_req_wr,
  input  wire [2:0]       i_sw_req_cmd,
  output reg  [2:0]       o_req_cmd,
  output reg              o_req_pending,
  input  wire             i_resp_rd,
  output reg              o_resp_valid,
  output reg  [TAG_W-1:0] o_resp_tag,
  output reg  [3:0]       o_resp_status,
  // hardware recovery and init
  input  wire             i_hw_err,
  input  wire             i_hw_init,
  output reg              o_recov_valid,
  output reg  [TAG_W-1:0] o_recov_tag,
  // input port state
  input  wire [TAG_W-1:0] i_expect_tag,
  input  wire             i_ack_pending,
  input  wire             i_retry_stop,
  input  wire             i_err_stop,
  input  wire             i_fatal,
  output wire             o_in_enable,
  output reg  [3:0]       o_in_status,
  // events
  output reg              o_dev_reset,
  output reg              o_proto_err,
  output reg              o_sym_err
);

  // ==========================================================
  // helpers
  function [3:0] sym_type;
    input [15:0] w;
    sym_type = w[`SYM_TYPE_HI:`SYM_TYPE_LO];
  endfunction

  function cmd_known;
    input [2:0] c;
    cmd_known = (c == `CMD_RESET) || (c == `CMD_STATUS) ||
                (c == `CMD_TRAIN);
  endfunction

  // a completed reset sequence restarts every flop below except the input synchroniser
  wire rst;
  assign rst = i_srst | o_dev_reset;

  // ==========================================================
  // link input synchroniser and edge finder
  reg        lclk_s1;
  reg        lclk_s2;
  reg        lclk_s3;
  reg [16:0] rxd_s1;
  reg [16:0] rxd_s2;

  // data is slow against the sampling clock, so it is stable
  // two cycles after the synchronised rising edge
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
      rxd_s1  <= 17'h00000;
      rxd_s2  <= 17'h00000;
    end else begin
      lclk_s1 <= i_lnk_clk;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      rxd_s1  <= {i_rx_ctl, i_rx_word};
      rxd_s2  <= rxd_s1;
    end
  end

  wire rx_edge;
  assign rx_edge = lclk_s2 & ~lclk_s3;

  // ==========================================================
  // aligned symbol pairing; words are whole symbols, so a
  // byte-wide port assembles them upstream and looks the same
  reg        have_first;
  reg [15:0] first_word;
  reg        sym_v;
  reg [15:0] sym;
  reg        pkt_v;

  always @(posedge i_ref_clk) begin
    if (rst) begin
      have_first <= 1'b0;
      first_word <= 16'h0000;
      sym_v      <= 1'b0;
      sym        <= 16'h0000;
      pkt_v      <= 1'b0;
      o_sym_err  <= 1'b0;
    end else begin
      sym_v     <= 1'b0;
      pkt_v     <= 1'b0;
      o_sym_err <= 1'b0;
      if (rx_edge) begin
        if (have_first) begin
          have_first <= 1'b0;
          if (rxd_s2[15:0] == ~first_word) begin
            sym_v <= 1'b1;
            sym   <= first_word;
          end else begin
            o_sym_err <= 1'b1;
          end
        end else if (rxd_s2[16]) begin
          have_first <= 1'b1;
          first_word <= rxd_s2[15:0];
        end else begin
          pkt_v <= 1'b1;
        end
      end
    end
  end

  wire [3:0] styp;
  wire [2:0] scmd;
  wire       is_req;
  assign styp   = sym_type(sym);
  assign scmd   = sym[`CMD_HI:`CMD_LO];
  assign is_req = sym_v && styp == `TYPE_LREQ && cmd_known(scmd);

  // ==========================================================
  // reset lockout
  reg [2:0] rst_cnt;

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rst_cnt     <= 3'h0;
      o_dev_reset <= 1'b0;
    end else begin
      o_dev_reset <= 1'b0;
      if (o_dev_reset) begin
        rst_cnt <= 3'h0;
      end else if (is_req && scmd == `CMD_RESET) begin
        if (rst_cnt == `RESET_COUNT - 3'h1) begin
          o_dev_reset <= 1'b1;
          rst_cnt     <= 3'h0;
        end else begin
          rst_cnt <= rst_cnt + 3'h1;
        end
      end else if (pkt_v || o_sym_err ||
                   (sym_v && styp != `TYPE_IDLE)) begin
        rst_cnt <= 3'h0;
      end
    end
  end

  // ==========================================================
  // inbound requests and input port state
  reg  resp_due;
  reg  train_req;
  wire resp_go;
  wire train_go;

  assign o_in_enable = (o_in_status == `STAT_OK);

  always @(posedge i_ref_clk) begin
    if (rst) begin
      resp_due    <= 1'b0;
      train_req   <= 1'b0;
      o_proto_err <= 1'b0;
      o_in_status <= `STAT_OK;
    end else begin
      o_proto_err <= 1'b0;
      if (train_go) begin
        train_req <= 1'b0;
      end
      if (resp_go) begin
        resp_due <= 1'b0;
      end
      // restarts first, so a fatal or error stop event below wins
      if (resp_go && (o_in_status == `STAT_ERR_STOP ||
                      o_in_status == `STAT_RETRY_STOP)) begin
        o_in_status <= `STAT_OK;
      end
      if (sym_v && styp == `TYPE_RESTART &&
          o_in_status == `STAT_RETRY_STOP) begin
        o_in_status <= `STAT_OK;
      end
      if (is_req && scmd == `CMD_STATUS) begin
        if (resp_due && !resp_go) begin
          o_proto_err <= 1'b1;
        end else begin
          resp_due <= 1'b1;
        end
      end
      if (is_req && scmd == `CMD_TRAIN) begin
        train_req <= 1'b1;
      end
      // fatal and error stop events take priority over any restart; a retry stop is taken only while the status is ok
      if (i_fatal) begin
        o_in_status <= `STAT_ERROR;
      end else if (o_in_status != `STAT_ERROR) begin
        if (i_err_stop || o_proto_err) begin
          o_in_status <= `STAT_ERR_STOP;
        end else if (i_retry_stop && o_in_enable) begin
          o_in_status <= `STAT_RETRY_STOP;
        end
      end
    end
  end

  // ==========================================================
  // outbound requests; no timeout, a silent peer keeps an
  // input-status request pending until reset
  reg  req_tosend;
  reg  req_by_hw;
  wire req_go;
  wire req_done;
  wire hw_req;
  wire sw_req;

  assign hw_req = i_hw_err | i_hw_init;
  assign sw_req = i_sw_req_wr & cmd_known(i_sw_req_cmd);

  always @(posedge i_ref_clk) begin
    if (rst) begin
      o_req_cmd     <= `CMD_TRAIN;
      o_req_pending <= 1'b0;
      req_tosend    <= 1'b0;
      req_by_hw     <= 1'b0;
      o_resp_valid  <= 1'b0;
      o_resp_tag    <= {TAG_W{1'b0}};
      o_resp_status <= `STAT_OK;
      o_recov_valid <= 1'b0;
      o_recov_tag   <= {TAG_W{1'b0}};
    end else begin
      o_recov_valid <= 1'b0;
      if (req_go) begin
        req_tosend <= 1'b0;
      end
      if (i_resp_rd) begin
        o_resp_valid <= 1'b0;
      end
      if (req_done && o_req_cmd != `CMD_STATUS) begin
        o_req_pending <= 1'b0;
      end
      if (sym_v && styp == `TYPE_LRESP && o_req_pending &&
          !req_tosend && o_req_cmd == `CMD_STATUS) begin
        o_req_pending <= 1'b0;
        o_resp_valid  <= 1'b1;
        o_resp_tag    <= sym[`TAG_LO+TAG_W-1:`TAG_LO];
        o_resp_status <= sym[3:0];
        if (req_by_hw) begin
          o_recov_valid <= 1'b1;
          o_recov_tag   <= sym[`TAG_LO+TAG_W-1:`TAG_LO];
        end
      end else if (!o_req_pending && (hw_req || sw_req)) begin
        o_req_pending <= 1'b1;
        req_tosend    <= 1'b1;
        req_by_hw     <= hw_req;
        o_req_cmd     <= hw_req ? `CMD_STATUS
                                : i_sw_req_cmd;
      end
    end
  end

  // ==========================================================
  // transmit sequencer
  localparam TX_IDLE  = 2'b00;
  localparam TX_SYM   = 2'b01;
  localparam TX_INV   = 2'b10;
  localparam TX_TRAIN = 2'b11;

  reg [1:0]  tx_st;
  reg [8:0]  train_cnt;
  reg        sent_req;

  assign o_tx_valid = (tx_st != TX_IDLE);
  assign o_training = (tx_st == TX_TRAIN);
  assign train_go   = (tx_st == TX_IDLE) && train_req;
  // earlier acknowledges drain before the response goes out
  assign resp_go    = (tx_st == TX_IDLE) && !train_req &&
                      resp_due && !i_ack_pending;
  assign req_go     = (tx_st == TX_IDLE) && !train_req &&
                      !(resp_due && !i_ack_pending) && req_tosend;
  assign req_done   = (tx_st == TX_INV) && i_tx_ready && sent_req;

  always @(posedge i_ref_clk) begin
    if (rst) begin
      tx_st     <= TX_IDLE;
      train_cnt <= 9'h000;
      sent_req  <= 1'b0;
      o_tx_word <= 16'h0000;
      o_tx_ctl  <= 1'b0;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          train_cnt <= 9'h000;
          if (train_go) begin
            tx_st     <= TX_TRAIN;
            o_tx_word <= `TRAIN_PATTERN;
            o_tx_ctl  <= 1'b0;
          end else if (resp_go) begin
            tx_st     <= TX_SYM;
            sent_req  <= 1'b0;
            o_tx_ctl  <= 1'b1;
            o_tx_word <= {`TYPE_LRESP, 1'b0,
                          i_expect_tag, 2'b00,
                          o_in_status};
          end else if (req_go) begin
            tx_st     <= TX_SYM;
            sent_req  <= 1'b1;
            o_tx_ctl  <= 1'b1;
            o_tx_word <= {`TYPE_LREQ, 9'h000,
                          o_req_cmd};
          end
        end
        TX_SYM: begin
          if (i_tx_ready) begin
            tx_st     <= TX_INV;
            o_tx_ctl  <= 1'b0;
            o_tx_word <= ~o_tx_word;
          end
        end
        TX_INV: begin
          if (i_tx_ready) begin
            tx_st <= TX_IDLE;
          end
        end
        TX_TRAIN: begin
          if (i_tx_ready) begin
            if (train_cnt == `TRAIN_COUNT - 9'h001) begin
              tx_st     <= TX_SYM;
              sent_req  <= 1'b0;
              o_tx_ctl  <= 1'b1;
              o_tx_word <= {`TYPE_IDLE, 12'h000};
            end else begin
              train_cnt <= train_cnt + 9'h001;
            end
          end
        end
        default: begin
          tx_st <= TX_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: tb/link_maint_checker.sv */
// concurrent checks on the link maintenance handler ports
`timescale 1ns/1ns
`include "link_maint_consts.vh"
module link_maint_checker #(
  parameter TAG_W = 5
) (
  // clock and reset
  input wire        i_ref_clk,
  input wire        i_srst,
  // transmit stream
  input wire        o_tx_valid,
  input wire        i_tx_ready,
  input wire [15:0] o_tx_word,
  input wire        o_tx_ctl,
  input wire        o_training,
  // requests and port state
  input wire        i_sw_req_wr,
  input wire [2:0]  i_sw_req_cmd,
  input wire [2:0]  o_req_cmd,
  input wire        o_req_pending,
  input wire        i_hw_err,
  input wire        i_hw_init,
  input wire        i_err_stop,
  input wire        i_fatal,
  input wire        o_in_enable,
  input wire [3:0]  o_in_status,
  input wire        o_dev_reset
);
  // ======
  // helper logic
  reg  [9:0] trn_cnt;
  wire       tx_go = o_tx_valid && i_tx_ready;
  wire       sw_ok = i_sw_req_wr && !o_req_pending && !i_hw_err && !i_hw_init;
  wire       known = (i_sw_req_cmd == `CMD_TRAIN) ||
                     (i_sw_req_cmd == `CMD_RESET) ||
                     (i_sw_req_cmd == `CMD_STATUS);
  // counts pattern words of the current training run only
  always @(posedge i_ref_clk) begin
    if (i_srst || !o_training)
      trn_cnt <= 10'h000;
    else if (tx_go)
      trn_cnt <= trn_cnt + 10'h001;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // ======
  // properties
  a_word_holds: assert property (
    o_tx_valid && !i_tx_ready && !o_dev_reset
    |=> o_tx_valid && $stable(o_tx_word) && $stable(o_tx_ctl))
    else $error("offered word changed before it was taken");
  a_inv_copy: assert property (
    tx_go && o_tx_ctl && !o_training && !o_dev_reset
    |=> o_tx_valid && !o_tx_ctl && o_tx_word == ~$past(o_tx_word))
    else $error("control word not followed by its inverse");
  a_req_taken: assert property (
    sw_ok && known |=> o_req_pending && o_req_cmd == $past(i_sw_req_cmd))
    else $error("request write not registered");
  a_req_emits: assert property (
    sw_ok && known |-> ##[1:4] o_tx_valid && o_tx_ctl &&
    o_tx_word[15:12] == `TYPE_LREQ)
    else $error("request symbol not offered");
  a_one_req: assert property (
    o_req_pending && i_sw_req_wr && !o_dev_reset |=> $stable(o_req_cmd))
    else $error("second request taken while one pending");
  a_undef_cmd: assert property (
    sw_ok && !known |=> !o_req_pending)
    else $error("undefined command accepted");
  a_enable_ok: assert property (
    o_in_enable == (o_in_status == `STAT_OK))
    else $error("input enable disagrees with status");
  a_err_stop: assert property (
    i_err_stop && !i_fatal && !o_dev_reset &&
    o_in_status != `STAT_ERROR
    |=> o_in_status == `STAT_ERR_STOP)
    else $error("error stop not entered");
  a_stop_holds: assert property (
    o_in_status == `STAT_ERR_STOP && !i_fatal && !o_dev_reset
    |=> o_in_status == `STAT_ERR_STOP ||
    (o_tx_valid && o_tx_ctl && o_tx_word[15:12] == `TYPE_LRESP))
    else $error("error stop left without a response");
  a_train_len: assert property (
    $fell(o_training) |-> trn_cnt == 10'h100 && o_tx_valid &&
    o_tx_ctl && o_tx_word == 16'h0000)
    else $error("training run length or trailing idle wrong");
  a_reset_clears: assert property (
    o_dev_reset |=> o_in_status == `STAT_OK && !o_req_pending)
    else $error("device reset left state behind");
endmodule

bind link_maint link_maint_checker #(.TAG_W(TAG_W)) chk_u (
  .i_ref_clk, .i_srst, .o_tx_valid, .i_tx_ready, .o_tx_word, .o_tx_ctl,
  .o_training, .i_sw_req_wr, .i_sw_req_cmd, .o_req_cmd, .o_req_pending,
  .i_hw_err, .i_hw_init, .i_err_stop, .i_fatal, .o_in_enable,
  .o_in_status, .o_dev_reset);

/* File: tb/link_peer.sv */
// far-end port model: sends symbols in, takes transmitted words
`timescale 1ns/1ns
module link_peer (
  // clock
  input  wire        i_ref_clk,
  // link toward the block
  output reg         o_lnk_clk,
  output reg  [15:0] o_rx_word,
  output reg         o_rx_ctl,
  // transmit handshake
  output reg         o_tx_ready
);
  integer seed;
  initial begin
    seed = 47;
    o_lnk_clk = 1'b0;
    o_rx_word = 16'hffff;
    o_rx_ctl = 1'b0;
    o_tx_ready = 1'b0;
  end
  // ======
  // stalls at random so both prompt and slow takes occur
  always @(posedge i_ref_clk) begin
    o_tx_ready <= ($random(seed) & 3) != 0;
  end
  // link clock only runs while a word is on the wire
  task send_word(input [15:0] w, input c);
    begin
      o_rx_word = w;
      o_rx_ctl = c;
      #16 o_lnk_clk = 1'b1;
      #16 o_lnk_clk = 1'b0;
    end
  endtask
  task send_sym(input [15:0] w, input bad);
    begin
      send_word(w, 1'b1);
      send_word(bad ? w ^ 16'h0001 : ~w, 1'b0);
      // released line must not keep the last value
      o_rx_word = ~o_rx_word;
    end
  endtask
endmodule

/* File: tb/link_maintenance_protocol_test.sv */
// self-checking bench for the link maintenance handler
`timescale 1ns/1ns
`include "link_maint_consts.vh"
module link_maintenance_protocol_test;
  // ======
  // signals
  reg         i_ref_clk, i_srst, i_sw_req_wr, i_resp_rd, i_hw_err;
  reg         i_hw_init, i_ack_pending, i_retry_stop, i_err_stop, i_fatal;
  reg  [2:0]  i_sw_req_cmd, c;
  reg  [4:0]  i_expect_tag, t, got_t;
  reg  [3:0]  st, s;
  wire        i_lnk_clk, i_rx_ctl, i_tx_ready, o_tx_valid, o_tx_ctl;
  wire        o_training, o_req_pending, o_resp_valid, o_recov_valid;
  wire        o_in_enable, o_dev_reset, o_proto_err, o_sym_err;
  wire [15:0] i_rx_word, o_tx_word;
  wire [2:0]  o_req_cmd;
  wire [4:0]  o_resp_tag, o_recov_tag;
  wire [3:0]  o_resp_status, o_in_status;
  integer     seed, err_count, cmp_count, i, k;
  reg  [16:0] obs_q[$], exp_q[$];

  link_maint #(.TAG_W(5)) dut_u (.i_ref_clk, .i_srst, .i_lnk_clk,
    .i_rx_word, .i_rx_ctl, .o_tx_valid, .i_tx_ready, .o_tx_word, .o_tx_ctl,
    .o_training, .i_sw_req_wr, .i_sw_req_cmd, .o_req_cmd, .o_req_pending,
    .i_resp_rd, .o_resp_valid, .o_resp_tag, .o_resp_status, .i_hw_err,
    .i_hw_init, .o_recov_valid, .o_recov_tag, .i_expect_tag,
    .i_ack_pending, .i_retry_stop, .i_err_stop, .i_fatal, .o_in_enable,
    .o_in_status, .o_dev_reset, .o_proto_err, .o_sym_err);
  link_peer peer_u (.i_ref_clk(i_ref_clk), .o_lnk_clk(i_lnk_clk),
    .o_rx_word(i_rx_word), .o_rx_ctl(i_rx_ctl), .o_tx_ready(i_tx_ready));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  // training words carry no control mark in the model
  always @(posedge i_ref_clk) begin
    if (o_tx_valid && i_tx_ready)
      obs_q.push_back({o_tx_ctl && !o_training, o_tx_word});
    s <= s | {o_recov_valid, o_sym_err, o_proto_err, o_dev_reset};
    if (o_recov_valid)
      got_t <= o_recov_tag;
  end
  // ======
  // shared tasks
  task complete_run;
    begin
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [39:0] nm, input [16:0] e, input [16:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (e !== g) begin
        err_count = err_count + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task rq(input [2:0] cm);
    begin
      peer_u.send_sym({`TYPE_LREQ, 9'h000, cm}, 1'b0);
      cyc(8);
    end
  endtask
  function [15:0] rsp(input [4:0] tg, input [3:0] sv);
    rsp = {`TYPE_LRESP, 1'b0, tg, 2'b00, sv};
  endfunction
  task exp_sym(input [15:0] w);
    begin
      exp_q.push_back({1'b1, w});
      exp_q.push_back({1'b0, ~w});
    end
  endtask
  // waits for the model's words, then looks for stray extras
  task drain(input [39:0] nm);
    integer n;
    begin
      n = 0;
      while (obs_q.size() < exp_q.size() && n < 3000) begin
        cyc(1);
        n = n + 1;
      end
      cyc(30);
      chk(nm, exp_q.size(), obs_q.size());
      if (n == 3000)
        complete_run;
      while (exp_q.size() > 0 && obs_q.size() > 0)
        chk(nm, exp_q.pop_front(), obs_q.pop_front());
      exp_q.delete();
      obs_q.delete();
    end
  endtask
  // ======
  // scenarios
  initial begin
    seed = 47;
    err_count = 0;
    cmp_count = 0;
    s = 4'h0;
    i_srst = 1'b1;
    i_sw_req_cmd = 3'h0;
    i_expect_tag = 5'h00;
    {i_sw_req_wr, i_resp_rd, i_hw_err, i_hw_init} = 4'h0;
    {i_ack_pending, i_retry_stop, i_err_stop, i_fatal} = 4'h0;
    cyc(5);
    i_srst <= 1'b0;
    cyc(2);
    chk("idle", 17'h00010, {o_tx_valid, o_req_pending, o_in_enable,
        o_in_status});
    t = $random(seed);
    i_expect_tag <= t;
    i_ack_pending <= 1'b1;
    rq(`CMD_STATUS);
    drain("hold");
    i_ack_pending <= 1'b0;
    exp_sym(rsp(t, `STAT_OK));
    drain("resp");
    for (k = 0; k < 3; k = k + 1) begin
      st = k ? `STAT_RETRY_STOP : `STAT_ERR_STOP;
      i_err_stop <= (k == 0);
      i_retry_stop <= (k != 0);
      cyc(1);
      {i_err_stop, i_retry_stop} <= 2'b00;
      cyc(2);
      chk("stop", st, {o_in_enable, o_in_status});
      // the last pass leaves retry stop to input-status alone
      if (k != 2)
        peer_u.send_sym({`TYPE_RESTART, 12'h000}, 1'b0);
      cyc(8);
      chk("rstrt", (k == 1) ? `STAT_OK : st, o_in_status);
      if (k != 1) begin
        rq(`CMD_STATUS);
        exp_sym(rsp(t, st));
        drain("stat");
        chk("clr", 17'h10, {o_in_enable, o_in_status});
      end
    end
    i_ack_pending <= 1'b1;
    rq(`CMD_STATUS);
    rq(`CMD_STATUS);
    chk("perr", 1'b1, s[1]);
    i_ack_pending <= 1'b0;
    cyc(60);
    obs_q.delete();
    peer_u.send_sym({`TYPE_LREQ, 9'h000, `CMD_RESET}, 1'b1);
    cyc(8);
    chk("serr", 1'b1, s[2]);
    drain("bad");
    // resets around a packet word must not count as four; an idle between them does not break the run
    for (i = 0; i < 9; i = i + 1) begin
      if (i == 3)
        peer_u.send_word(16'h1234, 1'b0);
      else if (i == 6)
        peer_u.send_sym(16'h0000, 1'b0);
      else
        rq(`CMD_RESET);
      if (i == 7) begin
        chk("lock", 1'b0, s[0]);
        i_err_stop <= 1'b1;
        cyc(1);
        i_err_stop <= 1'b0;
      end
    end
    chk("dev", 17'h30, {s[0], o_in_enable, o_in_status});
    rq(`CMD_TRAIN);
    for (i = 0; i < 256; i = i + 1)
      exp_q.push_back({1'b0, `TRAIN_PATTERN});
    exp_sym(16'h0000);
    drain("train");
    for (k = 0; k < 4; k = k + 1) begin
      c = (k == 0) ? `CMD_STATUS : (k == 1) ? `CMD_TRAIN :
          (k == 2) ? `CMD_RESET : 3'h5;
      i_sw_req_wr <= 1'b1;
      i_sw_req_cmd <= c;
      cyc(1);
      i_sw_req_wr <= (k < 3);
      i_sw_req_cmd <= `CMD_RESET;
      cyc(1);
      i_sw_req_wr <= 1'b0;
      cyc(1);
      chk("pend", (k < 3), o_req_pending);
      if (k < 3)
        chk("cmd", c, o_req_cmd);
      if (k < 3)
        exp_sym({`TYPE_LREQ, 9'h000, c});
      drain("req");
      if (k == 0) begin
        t = $random(seed);
        peer_u.send_sym(rsp(t, `STAT_RETRY_STOP), 1'b0);
        cyc(8);
        chk("rsp", {1'b1, t, `STAT_RETRY_STOP},
            {o_resp_valid, o_resp_tag, o_resp_status});
        i_resp_rd <= 1'b1;
        cyc(1);
        i_resp_rd <= 1'b0;
        cyc(2);
        chk("rd", 1'b0, {o_resp_valid, o_req_pending});
      end
    end
    for (k = 0; k < 2; k = k + 1) begin
      s = 4'h0;
      {i_hw_err, i_hw_init} <= k ? 2'b01 : 2'b10;
      cyc(1);
      {i_hw_err, i_hw_init} <= 2'b00;
      exp_sym({`TYPE_LREQ, 9'h000, `CMD_STATUS});
      drain("hwreq");
      t = $random(seed);
      peer_u.send_sym(rsp(t, `STAT_OK), 1'b0);
      cyc(8);
      chk("rec", {1'b1, t}, {s[3], got_t});
    end
    complete_run;
  end
endmodule
